//--- bsc_pkg.sv
`default_nettype none
// ****************************************************************
// Boundary scan chain constants
// ****************************************************************
package bsc_pkg;

  // Chain geometry
  localparam int unsigned CHAIN_LEN = 54;
  localparam int unsigned FIFO_DEPTH = 32;

  // Instruction codes
  localparam int unsigned IR_W = 5;
  localparam logic [4:0] IR_EXTEST = 5'h00;
  localparam logic [4:0] IR_SAMPLE = 5'h01;
  localparam logic [4:0] IR_CLAMP  = 5'h04;
  localparam logic [4:0] IR_HIGHZ  = 5'h05;
  localparam logic [4:0] IR_RESET  = 5'h1F;

  // Cell kinds
  localparam logic [2:0] CELL_OUT  = 3'h0;
  localparam logic [2:0] CELL_IN   = 3'h1;
  localparam logic [2:0] CELL_BI   = 3'h2;
  localparam logic [2:0] CELL_CTL  = 3'h3;
  localparam logic [2:0] CELL_INT  = 3'h4;

  // Kind of each cell, index 0 sits next to the serial output
  localparam logic [2:0] CELL_KIND [0:CHAIN_LEN-1] = '{
    CELL_OUT, CELL_OUT, CELL_OUT, CELL_IN,  CELL_IN,  CELL_IN,
    CELL_BI,  CELL_BI,  CELL_BI,  CELL_BI,  CELL_BI,  CELL_BI,
    CELL_CTL, CELL_BI,  CELL_BI,  CELL_BI,  CELL_BI,  CELL_BI,
    CELL_BI,  CELL_BI,  CELL_CTL, CELL_BI,  CELL_CTL, CELL_BI,
    CELL_CTL, CELL_BI,  CELL_CTL, CELL_BI,  CELL_CTL, CELL_BI,
    CELL_CTL, CELL_BI,  CELL_CTL, CELL_BI,  CELL_CTL, CELL_BI,
    CELL_BI,  CELL_BI,  CELL_INT, CELL_BI,  CELL_INT, CELL_BI,
    CELL_INT, CELL_INT, CELL_INT, CELL_CTL, CELL_INT, CELL_BI,
    CELL_INT, CELL_INT, CELL_INT, CELL_OUT, CELL_BI,  CELL_CTL};

  // Enable cell steering each two-way cell (0 where unused)
  localparam int unsigned CELL_CTRL [0:CHAIN_LEN-1] = '{
    0,  0,  0,  0,  0,  0,  12, 12, 12, 12, 12, 12,
    0,  12, 12, 12, 12, 12, 12, 20, 0,  22, 0,  24,
    0,  26, 0,  28, 0,  30, 0,  32, 0,  34, 0,  45,
    45, 45, 0,  45, 0,  45, 0,  0,  0,  0,  0,  45,
    0,  0,  0,  0,  53, 0};

  // Event word carried from the edge finder to the chain engine
  localparam int unsigned EVT_W     = 11;
  localparam int unsigned EVT_RISE  = 10;
  localparam int unsigned EVT_FALL  = 9;
  localparam int unsigned EVT_TDI   = 8;
  localparam int unsigned EVT_CAP   = 7;
  localparam int unsigned EVT_SHIFT = 6;
  localparam int unsigned EVT_UPD   = 5;
  localparam int unsigned EVT_IR_LO = 0;

  // Synchroniser word: tck, tdi, capture, shift, update, ir
  localparam int unsigned SYN_W = 10;

endpackage

`default_nettype wire

//--- bsc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Event FIFO
// ****************************************************************
module bsc_fifo
#(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 32
)
(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  // Handshakes and pointer arithmetic
  always_comb
  begin
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointer registers
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Storage
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  assign o_in_ready  = (count_reg != (AW+1)'(DEPTH)); // Full stalls the source
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];

endmodule
`default_nettype wire

//--- bsc_chain.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Boundary scan chain
// ****************************************************************
module bsc_chain
  import bsc_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  // Test port, from pins and the test state machine
  input  wire logic                 i_tck,
  input  wire logic                 i_tdi,
  input  wire logic                 i_capture_dr,
  input  wire logic                 i_shift_dr,
  input  wire logic                 i_update_dr,
  input  wire logic [IR_W-1:0]      i_ir,
  output logic                      o_tdo,
  output logic                      o_tdo_oe,
  // Engine stall
  input  wire logic                 i_scan_hold,
  // Core side, per cell (enable value for control cells)
  input  wire logic [CHAIN_LEN-1:0] i_core_data,
  output logic [CHAIN_LEN-1:0]      o_core_in,
  // Pad side, per cell
  input  wire logic [CHAIN_LEN-1:0] i_pad_in,
  output logic [CHAIN_LEN-1:0]      o_pad_out,
  output logic [CHAIN_LEN-1:0]      o_pad_oe
);

  // ****************************************************************
  // Input synchronisers and edge finder
  // ****************************************************************
  logic [SYN_W-1:0]     syn1_reg;
  logic [SYN_W-1:0]     syn2_reg;
  logic [CHAIN_LEN-1:0] pad1_reg;
  logic [CHAIN_LEN-1:0] pad2_reg;
  logic                 tck_prev_reg;
  logic                 tck_prev_next;
  logic                 evt_valid;
  logic                 evt_ready;
  logic [EVT_W-1:0]     evt_data;

  // Two flops on every outside input
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      syn1_reg <= '0;
      syn2_reg <= '0;
      pad1_reg <= '0;
      pad2_reg <= '0;
    end
    else
    begin
      syn1_reg <= {i_tck, i_tdi, i_capture_dr, i_shift_dr, i_update_dr, i_ir};
      syn2_reg <= syn1_reg;
      pad1_reg <= i_pad_in;
      pad2_reg <= pad1_reg;
    end
  end

  // An edge stays pending while the FIFO is full
  always_comb
  begin
    evt_valid     = syn2_reg[9] != tck_prev_reg;
    evt_data      = {syn2_reg[9], ~syn2_reg[9], syn2_reg[8:0]};
    tck_prev_next = (evt_valid && !evt_ready) ? tck_prev_reg : syn2_reg[9];
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      tck_prev_reg <= 1'b0;
    else
      tck_prev_reg <= tck_prev_next;
  end

  // ****************************************************************
  // Event FIFO
  // ****************************************************************
  logic             pop_valid;
  logic             pop_ready;
  logic [EVT_W-1:0] pop_data;

  bsc_fifo #(
    .WIDTH (EVT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_reset     (i_reset),
    .i_in_valid  (evt_valid),
    .o_in_ready  (evt_ready),
    .i_in_data   (evt_data),
    .o_out_valid (pop_valid),
    .i_out_ready (pop_ready),
    .o_out_data  (pop_data)
  );

  // ****************************************************************
  // Chain engine
  // ****************************************************************
  logic [CHAIN_LEN-1:0] chain_reg;
  logic [CHAIN_LEN-1:0] chain_next;
  logic [CHAIN_LEN-1:0] upd_reg;
  logic [CHAIN_LEN-1:0] upd_next;
  logic [CHAIN_LEN-1:0] cap_val;
  logic                 byp_reg;
  logic                 byp_next;
  logic [IR_W-1:0]      ir_reg;
  logic [IR_W-1:0]      ir_next;
  logic                 tdo_reg;
  logic                 tdo_next;
  logic                 tdo_oe_reg;
  logic                 tdo_oe_next;
  logic                 take;
  logic                 rise;
  logic                 fall;
  logic                 bsr_sel;
  logic [IR_W-1:0]      ev_ir;

  // Capture source per cell: pin level or core driver
  genvar g;
  generate
    for (g = 0; g < CHAIN_LEN; g++)
    begin : g_cap
      if (CELL_KIND[g] == CELL_IN || CELL_KIND[g] == CELL_BI)
        assign cap_val[g] = pad2_reg[g];
      else
        assign cap_val[g] = i_core_data[g];
    end
  endgenerate

  // Next chain, update latch, bypass bit and serial output
  always_comb
  begin
    take        = pop_valid && pop_ready;
    rise        = take && pop_data[EVT_RISE];
    fall        = take && pop_data[EVT_FALL];
    ev_ir       = pop_data[EVT_IR_LO +: IR_W];
    bsr_sel     = (ev_ir == IR_EXTEST) || (ev_ir == IR_SAMPLE);
    chain_next  = chain_reg;
    upd_next    = upd_reg;
    byp_next    = byp_reg;
    ir_next     = take ? ev_ir : ir_reg;
    tdo_next    = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (rise && pop_data[EVT_CAP])
    begin
      if (bsr_sel)
        chain_next = cap_val;
      else
        byp_next = 1'b0;
    end
    else if (rise && pop_data[EVT_SHIFT])
    begin
      if (bsr_sel)
        chain_next = {pop_data[EVT_TDI], chain_reg[CHAIN_LEN-1:1]};
      else
        byp_next = pop_data[EVT_TDI];
    end
    if (fall && pop_data[EVT_UPD] && bsr_sel)
      upd_next = chain_reg;
    if (fall)
    begin
      tdo_next    = bsr_sel ? chain_reg[0] : byp_reg;
      tdo_oe_next = pop_data[EVT_SHIFT];
    end
  end

  assign pop_ready = !i_scan_hold;

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      chain_reg  <= '0;
      upd_reg    <= '0;
      byp_reg    <= 1'b0;
      ir_reg     <= IR_RESET;
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end
    else
    begin
      chain_reg  <= chain_next;
      upd_reg    <= upd_next;
      byp_reg    <= byp_next;
      ir_reg     <= ir_next;
      tdo_reg    <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  // ****************************************************************
  // Pad and core drive
  // ****************************************************************
  logic                 test_drv;
  logic                 hiz;
  logic [CHAIN_LEN-1:0] pad_out_next;
  logic [CHAIN_LEN-1:0] pad_oe_next;
  logic [CHAIN_LEN-1:0] core_in_next;
  logic [CHAIN_LEN-1:0] pad_out_reg;
  logic [CHAIN_LEN-1:0] pad_oe_reg;
  logic [CHAIN_LEN-1:0] core_in_reg;

  assign test_drv = (ir_reg == IR_EXTEST) || (ir_reg == IR_CLAMP);
  assign hiz      = (ir_reg == IR_HIGHZ);

  // Per-cell drive by cell kind; control and internal cells own no pin
  generate
    for (g = 0; g < CHAIN_LEN; g++)
    begin : g_pad
      if (CELL_KIND[g] == CELL_OUT)
      begin : g_out
        assign pad_out_next[g] = test_drv ? upd_reg[g] : i_core_data[g];
        assign pad_oe_next[g]  = !hiz;
        assign core_in_next[g] = 1'b0;
      end
      else if (CELL_KIND[g] == CELL_BI)
      begin : g_bi
        assign pad_out_next[g] = test_drv ? upd_reg[g] : i_core_data[g];
        assign pad_oe_next[g]  = hiz ? 1'b0 : test_drv ? upd_reg[CELL_CTRL[g]]
                                 : i_core_data[CELL_CTRL[g]];
        assign core_in_next[g] = pad2_reg[g];
      end
      else if (CELL_KIND[g] == CELL_IN)
      begin : g_in
        assign pad_out_next[g] = 1'b0;
        assign pad_oe_next[g]  = 1'b0;
        assign core_in_next[g] = pad2_reg[g];
      end
      else
      begin : g_none
        assign pad_out_next[g] = 1'b0;
        assign pad_oe_next[g]  = 1'b0;
        assign core_in_next[g] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pad_out_reg <= '0;
      pad_oe_reg  <= '0;
      core_in_reg <= '0;
    end
    else
    begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg  <= pad_oe_next;
      core_in_reg <= core_in_next;
    end
  end

  assign o_pad_out = pad_out_reg;
  assign o_pad_oe  = pad_oe_reg;
  assign o_core_in = core_in_reg;
  assign o_tdo     = tdo_reg;
  assign o_tdo_oe  = tdo_oe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  property p_shift;
    rise && pop_data[EVT_SHIFT] && !pop_data[EVT_CAP] && bsr_sel |=>
      chain_reg == {$past(pop_data[EVT_TDI]), $past(chain_reg[CHAIN_LEN-1:1])};
  endproperty
  a_shift: assert property (p_shift) else $error("chain shift wrong");

  property p_capture;
    rise && pop_data[EVT_CAP] && bsr_sel |=>
      chain_reg[4] == $past(pad2_reg[4]) && chain_reg[0] == $past(i_core_data[0]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  property p_no_fall_capture;
    fall |=> chain_reg == $past(chain_reg);
  endproperty
  a_no_fall_capture: assert property (p_no_fall_capture) else $error("chain moved on fall");

  property p_update;
    fall && pop_data[EVT_UPD] && bsr_sel |=> upd_reg == $past(chain_reg);
  endproperty
  a_update: assert property (p_update) else $error("update wrong");

  property p_extest;
    ir_reg == IR_EXTEST ##1 ir_reg == IR_EXTEST |-> o_pad_out[51] == $past(upd_reg[51]);
  endproperty
  a_extest: assert property (p_extest) else $error("extest drive wrong");

  property p_sample;
    ir_reg == IR_SAMPLE |=> o_pad_out[0] == $past(i_core_data[0])
      && o_pad_oe[52] == $past(i_core_data[53]);
  endproperty
  a_sample: assert property (p_sample) else $error("sample not transparent");

  property p_clamp_byp;
    rise && pop_data[EVT_SHIFT] && !pop_data[EVT_CAP] && ev_ir == IR_CLAMP |=>
      byp_reg == $past(pop_data[EVT_TDI]) && chain_reg == $past(chain_reg);
  endproperty
  a_clamp_byp: assert property (p_clamp_byp) else $error("clamp bypass wrong");

  property p_highz;
    hiz |=> o_pad_oe == '0;
  endproperty
  a_highz: assert property (p_highz) else $error("pad driven in highz");

  property p_gate;
    ir_reg == IR_EXTEST |=> o_pad_oe[19] == $past(upd_reg[20]);
  endproperty
  a_gate: assert property (p_gate) else $error("enable cell ignored");

  property p_outonly;
    !hiz |=> o_pad_oe[1] && !o_pad_oe[12];
  endproperty
  a_outonly: assert property (p_outonly) else $error("cell kind drive wrong");

  c_shift: cover property (rise && pop_data[EVT_SHIFT] && bsr_sel);
  c_update: cover property (fall && pop_data[EVT_UPD] && bsr_sel);
  c_full: cover property (evt_valid && !evt_ready);
  c_highz: cover property (hiz ##1 !hiz);

endmodule
`default_nettype wire

//--- bsc_tester.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Boundary scan tester model
// ****************************************************************
module bsc_tester
  import bsc_pkg::*;
(
  // Test port drive
  output logic            o_tck,
  output logic            o_tdi,
  output logic            o_capture_dr,
  output logic            o_shift_dr,
  output logic            o_update_dr,
  output logic [IR_W-1:0] o_ir,
  // Test data return
  input  wire logic       i_tdo,
  input  wire logic       i_tdo_oe
);
  localparam realtime HALF = 62.5;
  logic last_tdo;

  // Idle levels: test clock stands low between frames
  initial
  begin
    {o_tck, o_tdi, o_capture_dr, o_shift_dr, o_update_dr} = '0;
    o_ir = 5'h1F;
    last_tdo = 1'b0;
  end

  // One test clock period; next state and data change mid high phase
  task automatic tick(input logic cap, input logic sh, input logic upd, input logic d,
                      output logic q);
    #(HALF);
    q = i_tdo_oe ? i_tdo : ~last_tdo;  // Released line reads as the inverse
    last_tdo = q;
    o_tck = 1'b1;
    #(HALF / 2.0);
    o_capture_dr = cap;
    o_shift_dr = sh;
    o_update_dr = upd;
    o_tdi = d;
    #(HALF / 2.0);
    o_tck = 1'b0;
  endtask

  // Load an instruction and run idle periods
  task automatic set_ir(input logic [IR_W-1:0] code, input int n);
    logic b;
    #(HALF / 2.0);
    o_ir = code;
    repeat (n) tick(1'b0, 1'b0, 1'b0, 1'b0, b);
  endtask

  // Capture, shift the whole chain, exit and update
  task automatic scan(input logic [CHAIN_LEN-1:0] d, output logic [CHAIN_LEN-1:0] q);
    logic b;
    #(HALF / 2.0);
    o_capture_dr = 1'b1;
    tick(1'b0, 1'b1, 1'b0, d[0], b);
    for (int i = 0; i < CHAIN_LEN; i++)
      tick(1'b0, i < CHAIN_LEN - 1, 1'b0, (i < CHAIN_LEN - 1) ? d[i + 1] : 1'b0, q[i]);
    tick(1'b0, 1'b0, 1'b1, 1'b0, b);
    tick(1'b0, 1'b0, 1'b0, 1'b0, b);
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Boundary scan chain testbench
// ****************************************************************
module tb_top
  import bsc_pkg::*;
;
  localparam logic [53:0] P1 = 54'h3A5C_96E1_0F7B_2D;
  localparam logic [53:0] P2 = 54'h1C3E_5A0F_96B4_E7;
  localparam logic [53:0] D1 = 54'h2B71_C0DE_3F49_A6;
  localparam logic [53:0] D2 = 54'h05F3_8E1A_C7D2_5B;
  localparam logic [53:0] D3 = 54'h3E0D_7A92_61CF_84;
  logic                 i_sys_clk;
  logic                 i_reset;
  logic                 tck, tdi, cap, sh, upd, tdo, tdo_oe, hold;
  logic [IR_W-1:0]      ir;
  logic [CHAIN_LEN-1:0] core, pad_in, core_in, pad_out, pad_oe, q, out_m, in_m;
  int                   errors;
  int                   checks_done;

  // Design and tester
  bsc_chain i_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_tck(tck), .i_tdi(tdi),
    .i_capture_dr(cap), .i_shift_dr(sh), .i_update_dr(upd), .i_ir(ir), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .i_scan_hold(hold), .i_core_data(core), .o_core_in(core_in),
    .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe));
  bsc_tester i_tester (.o_tck(tck), .o_tdi(tdi), .o_capture_dr(cap), .o_shift_dr(sh),
    .o_update_dr(upd), .o_ir(ir), .i_tdo(tdo), .i_tdo_oe(tdo_oe));

  // System clock
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Verdict and end of run
  task automatic summarize;
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Comparisons
  task automatic chk_vec(input logic [CHAIN_LEN-1:0] got, exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string what);
    chk_vec({53'h0, got}, {53'h0, exp}, what);
  endtask

  // Expected enables: output-only always drive, two-way follow their control cell
  function automatic logic [CHAIN_LEN-1:0] exp_oe(input logic [CHAIN_LEN-1:0] src);
    for (int k = 0; k < CHAIN_LEN; k++)
      exp_oe[k] = (CELL_KIND[k] == CELL_OUT) ? 1'b1 :
                  (CELL_KIND[k] == CELL_BI) ? src[CELL_CTRL[k]] : 1'b0;
  endfunction

  // Bounded wait for pads to settle, then compare
  task automatic wait_pads(input logic [CHAIN_LEN-1:0] om, eo, ee, input string what);
    @(negedge i_sys_clk);
    for (int n = 0; n < 20 && ((pad_out & om) !== eo || pad_oe !== ee); n++)
      @(negedge i_sys_clk);
    chk_vec(pad_out & om, eo, what);
    chk_vec(pad_oe, ee, what);
  endtask

  // Capture under SAMPLE with pins working normally; preload D1
  task automatic t_sample;
    @(negedge i_sys_clk);
    core = P1;
    pad_in = P1;
    i_tester.set_ir(IR_SAMPLE, 1);
    i_tester.scan(D1, q);
    chk_vec(q, P1, "sample capture");
    wait_pads(out_m, P1 & out_m, exp_oe(P1), "normal pads");
    chk_vec(core_in, P1 & in_m, "core inputs");
    chk_bit(tdo_oe, 1'b0, "tdo idle");
  endtask

  // Preloaded values drive pins, then a new update takes over
  task automatic t_extest;
    i_tester.set_ir(IR_EXTEST, 1);
    wait_pads(out_m, D1 & out_m, exp_oe(D1), "preload drive");
    @(negedge i_sys_clk);
    pad_in = P2;
    i_tester.scan(D2, q);
    chk_vec(q, (P2 & in_m) | (P1 & ~in_m), "extest capture");
    wait_pads(out_m, D2 & out_m, exp_oe(D2), "extest drive");
  endtask

  // Bypass bit between TDI and TDO; latch kept
  task automatic t_bypass(input logic [IR_W-1:0] code);
    logic hz;
    hz = (code == IR_HIGHZ);
    i_tester.set_ir(code, 1);
    i_tester.scan(D3, q);
    chk_vec(q, {D3[CHAIN_LEN-2:0], 1'b0}, "bypass path");
    wait_pads(hz ? '0 : out_m, hz ? '0 : D2 & out_m, hz ? '0 : exp_oe(D2),
              "bypass pads");
  endtask

  // Stalled engine queues edges; pads change only after release
  task automatic t_hold;
    @(negedge i_sys_clk);
    hold = 1'b1;
    i_tester.set_ir(IR_SAMPLE, 16);
    @(negedge i_sys_clk);
    chk_vec(pad_oe, '0, "held pads");
    @(negedge i_sys_clk);
    hold = 1'b0;
    wait_pads(out_m, P1 & out_m, exp_oe(P1), "released pads");
  endtask

  // Watchdog
  initial
  begin
    #200us;
    errors++;
    summarize();
  end

  // Main sequence
  initial
  begin
    for (int k = 0; k < CHAIN_LEN; k++)
    begin
      out_m[k] = (CELL_KIND[k] == CELL_OUT || CELL_KIND[k] == CELL_BI);
      in_m[k] = (CELL_KIND[k] == CELL_IN || CELL_KIND[k] == CELL_BI);
    end
    i_reset = 1'b1;
    hold = 1'b0;
    core = '0;
    pad_in = '0;
    errors = 0;
    checks_done = 0;
    repeat (16) @(negedge i_sys_clk);
    chk_vec(pad_oe, '0, "reset enables");
    i_reset = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    t_sample();
    t_extest();
    t_bypass(IR_CLAMP);
    t_bypass(IR_HIGHZ);
    t_hold();
    summarize();
  end
endmodule
`default_nettype wire
